/* File: hw/acsc_cfg.svh */
// Offsets, field positions, reset values and channel codes of the converter sequencing control
`ifndef ACSC_CFG_SVH
`define ACSC_CFG_SVH

`define ACSC_CTRL_ADDR     8'h11
`define ACSC_CTRL_RST      8'h00
`define ACSC_BIT_RSVD      7
`define ACSC_BIT_HALT      6
`define ACSC_BIT_IDLE      5
`define ACSC_BIT_SINGLE_CONVERSION_TRIGGER   4
`define ACSC_BIT_SPIN      3
`define ACSC_SEL_MSB       2
`define ACSC_SEL_LSB       0
`define ACSC_FC_SEL_MSB    1
`define ACSC_NUM_CH        5
`define ACSC_CH_TEMP       3'h0
`define ACSC_CH_SUPPLY     3'h1
`define ACSC_CH_BIAS       3'h2
`define ACSC_CH_MPD        3'h3
`define ACSC_CH_RX         3'h4
`define ACSC_CH_LAST       3'h4

`endif

/* File: hw/acsc_pkg.sv */
// Types and shared channel arithmetic of the converter sequencing control
`include "acsc_cfg.svh"

package acsc_pkg;

   typedef logic [2:0] acsc_ch_t;

   typedef enum logic {
      ACSC_ST_IDLE,
      ACSC_ST_CONV
   } acsc_state_t;

   // Round-robin successor over the five converter channels
   function automatic acsc_ch_t acsc_next_ch(input acsc_ch_t ch);
      acsc_next_ch = (ch >= `ACSC_CH_LAST) ? `ACSC_CH_TEMP : acsc_ch_t'(ch + 3'h1);
   endfunction

   // Illegal select codes fall back to temperature rather than an absent input
   function automatic acsc_ch_t acsc_decode_sel(input acsc_ch_t sel);
      acsc_decode_sel = (sel > `ACSC_CH_LAST) ? `ACSC_CH_TEMP : sel;
   endfunction

endpackage

/* File: hw/acsc_seq.sv */
// Conversion sequencer: starts, aborts and steps the converter through its channels
`include "acsc_cfg.svh"
module acsc_seq (
   input  wire logic               core_clk,
   input  wire logic               rst,
   acsc_seq_if.seq                 sif,
   input  wire logic               conv_done,
   output logic                    conv_start,
   output logic                    conv_abort,
   output acsc_pkg::acsc_ch_t      conv_channel
);

   acsc_pkg::acsc_state_t state_ff, nxt_state;
   logic                  start_ff, nxt_start;
   logic                  abort_ff, nxt_abort;
   acsc_pkg::acsc_ch_t    ch_ff, nxt_ch;
   acsc_pkg::acsc_ch_t    first_ch;

   // =====================================================================
   // Sequencing
   // =====================================================================
   always_comb begin
      first_ch   = sif.spin_en ? acsc_pkg::acsc_decode_sel(sif.spin_ch)
                               : acsc_pkg::acsc_next_ch(ch_ff);
      nxt_state  = state_ff;
      nxt_start  = 1'b0;
      nxt_abort  = 1'b0;
      nxt_ch     = ch_ff;
      sif.res_we = 1'b0;
      unique case (state_ff)
         acsc_pkg::ACSC_ST_IDLE: begin
            if (sif.run) begin
               nxt_state = acsc_pkg::ACSC_ST_CONV;
               nxt_start = 1'b1;
               nxt_ch    = first_ch;
            end
         end
         acsc_pkg::ACSC_ST_CONV: begin
            // A halt drops the conversion in flight so no result is produced
            if (!sif.run) begin
               nxt_state = acsc_pkg::ACSC_ST_IDLE;
               nxt_abort = 1'b1;
            end else if (conv_done) begin
               sif.res_we = 1'b1;
               if (sif.stop_after) begin
                  nxt_state = acsc_pkg::ACSC_ST_IDLE;
               end else begin
                  nxt_start = 1'b1;
                  nxt_ch    = first_ch;
               end
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_ff <= acsc_pkg::ACSC_ST_IDLE;
         start_ff <= 1'b0;
         abort_ff <= 1'b0;
         ch_ff    <= `ACSC_CH_LAST;
      end else begin
         state_ff <= nxt_state;
         start_ff <= nxt_start;
         abort_ff <= nxt_abort;
         ch_ff    <= nxt_ch;
      end
   end

   assign sif.busy     = (state_ff == acsc_pkg::ACSC_ST_CONV);
   assign sif.res_ch   = ch_ff;
   assign conv_start   = start_ff;
   assign conv_abort   = abort_ff;
   assign conv_channel = ch_ff;

   // =====================================================================
   // Checks
   // =====================================================================
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   AST_ROUND_ROBIN: assert property (conv_start && !$past(sif.spin_en)
      |-> conv_channel == acsc_pkg::acsc_next_ch($past(conv_channel)))
      else $error("free-running channel did not advance round-robin");
   AST_START_BUSY: assert property (conv_start |-> sif.busy)
      else $error("conversion started without busy state");

endmodule

/* File: hw/acsc_seq_if.sv */
// Link between the control register logic and the conversion sequencer
interface acsc_seq_if;
   logic               run;
   logic               stop_after;
   logic               spin_en;
   acsc_pkg::acsc_ch_t spin_ch;
   logic               busy;
   logic               res_we;
   acsc_pkg::acsc_ch_t res_ch;

   modport ctrl (output run, output stop_after, output spin_en, output spin_ch,
                 input busy, input res_we, input res_ch);
   modport seq  (input run, input stop_after, input spin_en, input spin_ch,
                 output busy, output res_we, output res_ch);
endinterface

/* File: hw/acsc_top.sv */
// Converter sequencing control register with halt, single-conversion and single-channel modes
`include "acsc_cfg.svh"

module acsc_top #(
   parameter int RES_W = 16
) (
   input  wire logic               core_clk,
   input  wire logic               rst,
   input  wire logic [7:0]         reg_addr,
   input  wire logic               reg_wr_en,
   input  wire logic [7:0]         reg_wdata,
   output logic      [7:0]         reg_rdata,
   input  wire logic               pw_valid,
   input  wire logic               fc_spin_mode,
   output logic      [1:0]         fc_channel_sel,
   output logic                    conv_start,
   output logic                    conv_abort,
   output logic      [2:0]         conv_channel,
   input  wire logic               conv_done,
   input  wire logic [RES_W-1:0]   conv_data,
   input  wire logic [2:0]         res_sel,
   output logic      [RES_W-1:0]   res_data,
   output logic                    tcomp_update,
   output logic                    limit_check,
   output logic      [2:0]         limit_check_ch
);

   acsc_seq_if sif ();

   logic                  halt_ff, nxt_halt;
   logic                  single_conversion_trigger_ff, nxt_single_conversion_trigger;
   logic                  done_ff, nxt_done;
   logic                  spin_ff, nxt_spin;
   acsc_pkg::acsc_ch_t    sel_ff, nxt_sel;
   logic [7:0]            rdata_ff, nxt_rdata;
   logic                  tcomp_ff, nxt_tcomp;
   logic                  limit_ff, nxt_limit;
   acsc_pkg::acsc_ch_t    limit_ch_ff, nxt_limit_ch;
   logic [1:0]            fc_sel_ff, nxt_fc_sel;
   logic [RES_W-1:0]      res_data_ff, nxt_res_data;
   logic [RES_W-1:0]      res_mem [`ACSC_NUM_CH];
   logic                  hit;
   logic                  ctrl_wr;
   logic                  single_conversion_trigger_end;
   logic [7:0]            ctrl_image;

   // =====================================================================
   // Register access
   // =====================================================================
   // Without a valid password the register neither takes writes nor shows its contents
   assign hit     = pw_valid && (reg_addr == `ACSC_CTRL_ADDR);
   assign ctrl_wr = hit && reg_wr_en;

   // Reserved top bit is undefined on read; it is returned as zero here
   always_comb begin
      ctrl_image                               = `ACSC_CTRL_RST;
      ctrl_image[`ACSC_BIT_HALT]               = halt_ff;
      ctrl_image[`ACSC_BIT_IDLE]               = !sif.busy;
      ctrl_image[`ACSC_BIT_SINGLE_CONVERSION_TRIGGER]            = single_conversion_trigger_ff;
      ctrl_image[`ACSC_BIT_SPIN]               = spin_ff;
      ctrl_image[`ACSC_SEL_MSB:`ACSC_SEL_LSB]  = sel_ff;
   end

   assign single_conversion_trigger_end = sif.res_we && single_conversion_trigger_ff;

   always_comb begin
      nxt_halt    = halt_ff;
      nxt_single_conversion_trigger = single_conversion_trigger_ff;
      nxt_spin    = spin_ff;
      nxt_sel     = sel_ff;
      nxt_rdata   = hit ? ctrl_image : 8'h00;
      if (ctrl_wr) begin
         nxt_halt    = reg_wdata[`ACSC_BIT_HALT];
         nxt_single_conversion_trigger = reg_wdata[`ACSC_BIT_SINGLE_CONVERSION_TRIGGER];
         nxt_spin    = reg_wdata[`ACSC_BIT_SPIN];
         nxt_sel     = reg_wdata[`ACSC_SEL_MSB:`ACSC_SEL_LSB];
      end
      // Any write re-arms a finished single conversion; a completion in the
      // same cycle wins so the result just taken is not repeated silently
      nxt_done = single_conversion_trigger_end || (done_ff && !ctrl_wr);
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         halt_ff    <= 1'b0;
         single_conversion_trigger_ff <= 1'b0;
         done_ff    <= 1'b0;
         spin_ff    <= 1'b0;
         sel_ff     <= `ACSC_CH_TEMP;
         rdata_ff   <= 8'h00;
      end else begin
         halt_ff    <= nxt_halt;
         single_conversion_trigger_ff <= nxt_single_conversion_trigger;
         done_ff    <= nxt_done;
         spin_ff    <= nxt_spin;
         sel_ff     <= nxt_sel;
         rdata_ff   <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;

   // =====================================================================
   // Sequencer steering
   // =====================================================================
   // Run stops on halt and after a finished single conversion until re-armed
   assign sif.run        = !halt_ff && !(single_conversion_trigger_ff && done_ff);
   assign sif.stop_after = single_conversion_trigger_ff;
   assign sif.spin_en    = spin_ff;
   assign sif.spin_ch    = sel_ff;

   acsc_seq u_seq (
      .core_clk     (core_clk),
      .rst          (rst),
      .sif          (sif),
      .conv_done    (conv_done),
      .conv_start   (conv_start),
      .conv_abort   (conv_abort),
      .conv_channel (conv_channel)
   );

   // =====================================================================
   // Results and downstream strobes
   // =====================================================================
   // Results are written only on a completed, non-aborted conversion
   always_ff @(posedge core_clk) begin
      if (sif.res_we && !halt_ff) begin
         res_mem[sif.res_ch] <= conv_data;
      end
   end

   always_comb begin
      nxt_res_data = res_data_ff;
      if (res_sel <= `ACSC_CH_LAST) begin
         nxt_res_data = res_mem[res_sel];
      end
      nxt_tcomp    = sif.res_we && !halt_ff && (sif.res_ch == `ACSC_CH_TEMP);
      nxt_limit    = sif.res_we && !halt_ff;
      nxt_limit_ch = sif.res_we ? sif.res_ch : limit_ch_ff;
      // Only the low select bits reach the fault comparator; its own mode
      // must not be on together with converter single-channel mode
      nxt_fc_sel   = fc_spin_mode ? sel_ff[`ACSC_FC_SEL_MSB:0] : 2'h0;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         res_data_ff <= '0;
         tcomp_ff    <= 1'b0;
         limit_ff    <= 1'b0;
         limit_ch_ff <= `ACSC_CH_TEMP;
         fc_sel_ff   <= 2'h0;
      end else begin
         res_data_ff <= nxt_res_data;
         tcomp_ff    <= nxt_tcomp;
         limit_ff    <= nxt_limit;
         limit_ch_ff <= nxt_limit_ch;
         fc_sel_ff   <= nxt_fc_sel;
      end
   end

   assign res_data       = res_data_ff;
   assign tcomp_update   = tcomp_ff;
   assign limit_check    = limit_ff;
   assign limit_check_ch = limit_ch_ff;
   assign fc_channel_sel = fc_sel_ff;

   // =====================================================================
   // Check helpers
   // =====================================================================
   // Starts since the last register write; saturates so a runaway
   // sequencer cannot wrap the count back into the legal range
   logic [1:0]            os_starts_ff, nxt_os_starts;

   always_comb begin
      nxt_os_starts = os_starts_ff;
      if (ctrl_wr) begin
         nxt_os_starts = 2'h0;
      end else if (conv_start && (os_starts_ff != 2'h3)) begin
         nxt_os_starts = os_starts_ff + 2'h1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         os_starts_ff <= 2'h0;
      end else begin
         os_starts_ff <= nxt_os_starts;
      end
   end

   // =====================================================================
   // Checks
   // =====================================================================
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   AST_HALT_NO_START: assert property (halt_ff && $past(halt_ff) |-> !conv_start)
      else $error("conversion started while halted");
   AST_HALT_NO_STORE: assert property (halt_ff |-> !sif.res_we)
      else $error("result stored while halted");
   AST_HALT_NO_TCOMP: assert property (halt_ff && $past(halt_ff) |-> !tcomp_update)
      else $error("compensation update while halted");
   AST_HALT_NO_LIMIT: assert property (halt_ff && $past(halt_ff) |-> !limit_check)
      else $error("limit comparison while halted");
   AST_IDLE_READ: assert property (hit |=> reg_rdata[`ACSC_BIT_IDLE] == !$past(sif.busy))
      else $error("idle flag does not reflect converter state");
   AST_SINGLE_CONVERSION_TRIGGER_STOP: assert property (single_conversion_trigger_end && !ctrl_wr |=> !sif.busy && done_ff)
      else $error("single conversion did not stop the converter");
   AST_SINGLE_CONVERSION_TRIGGER_HOLD: assert property (single_conversion_trigger_ff && done_ff |-> !conv_start ##1 !conv_start)
      else $error("converter restarted before re-arm");
   AST_RETRIGGER: assert property (ctrl_wr && reg_wdata[`ACSC_BIT_SINGLE_CONVERSION_TRIGGER]
      && !reg_wdata[`ACSC_BIT_HALT] && !sif.busy && !conv_start |-> ##2 conv_start)
      else $error("single conversion not retriggered");
   AST_SPIN_CH: assert property (conv_start && $past(spin_ff)
      |-> conv_channel == acsc_pkg::acsc_decode_sel($past(sel_ff)))
      else $error("single-channel mode converted wrong channel");
   AST_PW_GATE: assert property (reg_wr_en && !pw_valid |=> $stable(halt_ff) && $stable(sel_ff))
      else $error("write accepted without password");

   // =====================================================================
   // Checks: halt and abort
   // =====================================================================
   AST_ABORT_ON_HALT: assert property (sif.busy && !sif.run
      |=> conv_abort && !sif.busy)
      else $error("halt did not abort the conversion in flight");
   AST_ABORT_CAUSE: assert property (conv_abort
      |-> $past(sif.busy) && $past(halt_ff))
      else $error("abort without a halt during a conversion");
   AST_HALT_IDLE: assert property (halt_ff && $past(halt_ff)
      |-> !sif.busy)
      else $error("converter busy while halted");
   AST_ABORT_NO_RESULT: assert property (conv_abort
      |-> !limit_check && !tcomp_update)
      else $error("aborted conversion produced a result");
   AST_RESUME: assert property (!halt_ff && $past(halt_ff) && !single_conversion_trigger_ff
      |-> ##1 conv_start)
      else $error("converter did not resume after halt was cleared");

   // =====================================================================
   // Checks: register image and downstream strobes
   // =====================================================================
   AST_WR_LANDS: assert property (ctrl_wr
      |=> (ctrl_image & 8'h5f) == ($past(reg_wdata) & 8'h5f))
      else $error("register write did not land in the writable fields");
   AST_RSVD_ZERO: assert property (hit
      |=> !reg_rdata[`ACSC_BIT_RSVD])
      else $error("reserved bit read back as one");
   AST_NO_PW_READ: assert property (!hit
      |=> reg_rdata == 8'h00)
      else $error("register contents shown without password");
   AST_LIMIT_FOLLOWS: assert property (sif.res_we
      |=> limit_check && limit_check_ch == $past(sif.res_ch))
      else $error("stored result not passed to limit comparison");
   AST_TCOMP_TEMP: assert property (tcomp_update
      |-> limit_check && limit_check_ch == `ACSC_CH_TEMP)
      else $error("compensation update for a channel other than temperature");
   AST_FC_SEL: assert property (fc_spin_mode
      |=> fc_channel_sel == 2'($past(sel_ff)))
      else $error("fault comparator channel not taken from low select bits");
   AST_FC_OFF: assert property (!fc_spin_mode
      |=> fc_channel_sel == 2'h0)
      else $error("fault comparator channel set outside its mode");

   // =====================================================================
   // Checks: single conversion and channel stepping
   // =====================================================================
   AST_SINGLE_CONVERSION_TRIGGER_ONCE: assert property (single_conversion_trigger_ff
      |-> os_starts_ff <= 2'h1)
      else $error("more than one conversion for one single-conversion request");
   AST_DONE_CLEARS: assert property (ctrl_wr && !single_conversion_trigger_end
      |=> !done_ff)
      else $error("register write did not re-arm single conversion");
   AST_STOP_AFTER: assert property (sif.res_we && sif.stop_after
      |=> !conv_start && !sif.busy)
      else $error("converter went on after the single conversion");
   AST_NEXT_START: assert property (sif.res_we && !sif.stop_after
      |=> conv_start)
      else $error("converter did not go on to the next channel");
   AST_CH_LEGAL: assert property (conv_start
      |-> conv_channel <= `ACSC_CH_LAST)
      else $error("conversion started on an absent channel");

   COV_SINGLE_CONVERSION_TRIGGER: cover property (ctrl_wr && reg_wdata[`ACSC_BIT_SINGLE_CONVERSION_TRIGGER] ##[1:200] single_conversion_trigger_end);
   COV_HALT_ABORT: cover property (conv_abort);
   COV_SPIN_RX: cover property (conv_start && spin_ff && conv_channel == `ACSC_CH_RX);
   COV_RETRIGGER: cover property (single_conversion_trigger_ff && done_ff ##1 ctrl_wr ##[1:4] conv_start);
   COV_SPIN_ILLEGAL: cover property (conv_start && spin_ff && sel_ff > `ACSC_CH_LAST);

endmodule

/* File: tb/acsc_conv_model.sv */
// Behavioural converter answering each start that is not aborted with a done after a settable delay
module acsc_conv_model #(
   parameter int RES_W = 16
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             conv_start,
   input  wire logic             conv_abort,
   input  wire logic [2:0]       conv_channel,
   input  wire logic [7:0]       lat,
   output logic                  conv_done,
   output logic [RES_W-1:0]      conv_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       busy;
   logic [7:0] cnt;
   logic [7:0] seq;
   logic [2:0] ch;
   // ====================
   // Conversion engine
   // Data toggles outside done so a sample at the wrong cycle is seen
   initial begin
      conv_done = 1'b0;
      conv_data = '0;
      busy = 1'b0;
      seq = 8'h00;
      forever begin
         @(posedge core_clk);
         #1;
         conv_done = 1'b0;
         conv_data = ~conv_data;
         if (rst || conv_abort) begin
            busy = 1'b0;
         end else if (conv_start) begin
            busy = 1'b1;
            cnt = lat;
            ch = conv_channel;
         end else if (busy && cnt != 8'h00) begin
            cnt = cnt - 8'h01;
         end else if (busy) begin
            conv_done = 1'b1;
            conv_data = RES_W'({seq, 5'h00, ch});
            seq = seq + 8'h01;
            busy = 1'b0;
         end
      end
   end
endmodule

/* File: tb/tb_top.sv */
// Testbench of the converter sequencing control: register, sequencing and result checks
`include "acsc_cfg.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] CA = `ACSC_CTRL_ADDR;
   logic        core_clk, rst, reg_wr_en, pw_valid, fc_spin_mode;
   logic        conv_start, conv_abort, conv_done, tcomp_update, limit_check;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, lat;
   logic [1:0]  fc_channel_sel;
   logic [2:0]  conv_channel, res_sel, limit_check_ch;
   logic [15:0] conv_data, res_data;
   int          n_fail = 0;
   int          check_count = 0;
   int          n_start = 0;
   int          n_abort = 0;
   int          n_lim = 0;
   int          n_tc = 0;
   logic [2:0]  ch_q[$];
   logic [2:0]  lim_ch;

   acsc_top #(.RES_W(16)) DUT (
      .core_clk       (core_clk),
      .rst            (rst),
      .reg_addr       (reg_addr),
      .reg_wr_en      (reg_wr_en),
      .reg_wdata      (reg_wdata),
      .reg_rdata      (reg_rdata),
      .pw_valid       (pw_valid),
      .fc_spin_mode   (fc_spin_mode),
      .fc_channel_sel (fc_channel_sel),
      .conv_start     (conv_start),
      .conv_abort     (conv_abort),
      .conv_channel   (conv_channel),
      .conv_done      (conv_done),
      .conv_data      (conv_data),
      .res_sel        (res_sel),
      .res_data       (res_data),
      .tcomp_update   (tcomp_update),
      .limit_check    (limit_check),
      .limit_check_ch (limit_check_ch)
   );
   acsc_conv_model #(.RES_W(16)) conv_model (
      .core_clk     (core_clk),
      .rst          (rst),
      .conv_start   (conv_start),
      .conv_abort   (conv_abort),
      .conv_channel (conv_channel),
      .lat          (lat),
      .conv_done    (conv_done),
      .conv_data    (conv_data)
   );

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // ====================
   // Event monitor: pulses are looked at mid-cycle, away from the edge that launches them
   always @(negedge core_clk) begin
      if (conv_start === 1'b1) begin
         n_start = n_start + 1;
         ch_q.push_back(conv_channel);
      end
      if (limit_check === 1'b1) begin
         lim_ch = limit_check_ch;
      end
      n_abort += int'(conv_abort === 1'b1);
      n_lim += int'(limit_check === 1'b1);
      n_tc += int'(tcomp_update === 1'b1);
   end
   // ====================
   // Shared tasks
   task automatic final_report();
      $display("checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic pw);
      cyc(1);
      reg_addr = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      pw_valid = pw;
      cyc(1);
      reg_wr_en = 1'b0;
      pw_valid = 1'b1;
   endtask
   task automatic rd(input logic pw, output logic [7:0] d);
      cyc(1);
      reg_addr = CA;
      pw_valid = pw;
      cyc(1);
      d = reg_rdata;
      pw_valid = 1'b1;
   endtask
   task automatic rres(input logic [2:0] c, output logic [15:0] d);
      cyc(1);
      res_sel = c;
      cyc(1);
      d = res_data;
   endtask
   // Bounded waits: a timeout is a mismatch and ends the run
   task automatic wait_starts(input int n);
      int goal;
      goal = n_start + n;
      for (int i = 0; i < 400 && n_start < goal; i++) cyc(1);
      if (n_start < goal) begin
         cmp("converter start count", 16'(goal), 16'(n_start));
         final_report();
      end
   endtask
   task automatic wait_idle();
      logic [7:0] d;
      d = 8'h00;
      for (int i = 0; i < 100 && d[5] !== 1'b1; i++) rd(1'b1, d);
      cmp("idle flag after conversion", 16'h0001, 16'(d[5]));
      if (d[5] !== 1'b1) final_report();
   endtask
   // ====================
   // Scenarios
   task automatic t_reset_freerun();
      logic [7:0] d;
      rd(1'b1, d);
      cmp("control after reset", 16'h0000, 16'(d & 8'hdf));
      wait_starts(6);
      for (int i = 0; i < 6; i++) cmp("free-run channel", 16'(i % 5), 16'(ch_q[i]));
      cmp("limit comparisons", 16'h0001, 16'(n_lim > 4));
      cmp("compensation updates", 16'h0001, 16'(n_tc > 0));
   endtask
   task automatic t_access();
      logic [7:0] d;
      int s0;
      wr(CA, 8'h40, 1'b0);
      wr(8'h12, 8'h40, 1'b1);
      s0 = n_start;
      cyc(10);
      cmp("starts after refused writes", 16'h0001, 16'(n_start > s0));
      rd(1'b0, d);
      cmp("read without password", 16'h0000, 16'(d));
      wr(CA, 8'h03, 1'b1);
      rd(1'b1, d);
      cmp("reserved and select bits", 16'h0003, 16'(d & 8'hdf));
      fc_spin_mode = 1'b1;
      cyc(3);
      cmp("fault comparator channel", 16'h0003, 16'(fc_channel_sel));
      fc_spin_mode = 1'b0;
      cyc(3);
      cmp("fault comparator channel off", 16'h0000, 16'(fc_channel_sel));
   endtask
   task automatic t_spin();
      logic [15:0] r;
      logic [2:0]  e;
      int q0;
      for (int c = 0; c < 6; c++) begin
         e = (c > 4) ? 3'h0 : 3'(c);
         wr(CA, 8'h08 | 8'(c), 1'b1);
         wait_starts(2);
         q0 = ch_q.size();
         wait_starts(3);
         for (int k = q0; k < q0 + 3; k++) cmp("spin channel", 16'(e), 16'(ch_q[k]));
         rres(e, r);
         cmp("spin result channel", 16'(e), 16'(r[2:0]));
         cmp("limit channel", 16'(e), 16'(lim_ch));
      end
   endtask
   task automatic t_halt();
      logic [7:0]  d;
      logic [15:0] r0[5];
      logic [15:0] r1;
      int s0, l0, t0, a0;
      lat = 8'h08;
      wr(CA, 8'h00, 1'b1);
      wait_starts(2);
      rd(1'b1, d);
      cmp("idle flag while busy", 16'h0000, 16'(d[5]));
      a0 = n_abort;
      wr(CA, 8'h40, 1'b1);
      cyc(3);
      cmp("abort on halt", 16'h0001, 16'(n_abort - a0));
      for (int c = 0; c < 5; c++) rres(3'(c), r0[c]);
      s0 = n_start;
      l0 = n_lim;
      t0 = n_tc;
      cyc(40);
      cmp("starts while halted", 16'h0000, 16'(n_start - s0));
      cmp("compares while halted", 16'h0000, 16'(n_lim - l0));
      cmp("compensation while halted", 16'h0000, 16'(n_tc - t0));
      for (int c = 0; c < 5; c++) begin
         rres(3'(c), r1);
         cmp("result held", r0[c], r1);
      end
      rd(1'b1, d);
      cmp("idle flag while halted", 16'h0001, 16'(d[5]));
   endtask
   task automatic t_single_conversion_trigger();
      int s0;
      lat = 8'h03;
      s0 = n_start;
      wr(CA, 8'h10, 1'b1);
      wait_idle();
      cmp("one-shot starts", 16'h0001, 16'(n_start - s0));
      cyc(30);
      cmp("starts after one-shot", 16'h0001, 16'(n_start - s0));
      wr(CA, 8'h10, 1'b1);
      wait_idle();
      cyc(10);
      cmp("repeated one-shot starts", 16'h0002, 16'(n_start - s0));
      wr(CA, 8'h00, 1'b1);
      wait_starts(3);
   endtask
   // ====================
   // Main sequence
   initial begin
      rst = 1'b1;
      reg_addr = CA;
      reg_wr_en = 1'b0;
      reg_wdata = 8'h00;
      pw_valid = 1'b1;
      fc_spin_mode = 1'b0;
      res_sel = 3'h0;
      lat = 8'h00;
      cyc(5);
      rst = 1'b0;
      t_reset_freerun();
      t_access();
      t_spin();
      t_halt();
      t_single_conversion_trigger();
      final_report();
   end
endmodule
